// [shared/aip_defs.vh]
// Constants for the analog input, monitor output and PID setpoint block.
//
// Contract
// - Analog input drives the frequency command only when frequency source code is 01.
// - Unassigned analog type select function reads as OFF.
// - Select OFF in the default configuration picks the voltage input.
// - Config 02 pot/voltage, 03 pot/current, 04 voltage, 05 current by select line.
// - Voltage and current inputs are never used together for setpoint and process variable.
// - Monitor output spans 0 to +10V, positive only, same for both rotations.
// - Monitor select 00 shows frequency to max, 01 shows current to 200%.
// - Monitor gain accepts 0 to 255, default 100, sets full-scale voltage.
// - Monitor offset accepts 0.0 to 10.0, default 0.0, shifts the characteristic.
// - Without PID the reference is fixed value, panel pot or analog input.
// - PID enable code 01 makes the loop compute the target frequency.
// - The process variable comes from the voltage or the current input.
// - A scale factor converts process variable units to motor frequency.
// - Within the limit the PID controller operates linearly.
// - Beyond the limit the output is moved so the difference never exceeds it.
// - Error sign selects setpoint minus process variable or its negation.
// - The loop drives the output frequency to reduce the loop error.
`ifndef AIP_DEFS_VH
`define AIP_DEFS_VH

// Register byte offsets.
`define AIP_REG_SRC_CFG    8'h00
`define AIP_REG_FIXED_FREQ 8'h04
`define AIP_REG_MON_CFG    8'h08
`define AIP_REG_PID_CFG    8'h0C
`define AIP_REG_PID_GAIN   8'h10
`define AIP_REG_STATUS     8'h14

// Field codes.
`define AIP_FSRC_POT       2'h0
`define AIP_FSRC_ANALOG    2'h1
`define AIP_FSRC_FIXED     2'h2
`define AIP_CFG_POT_VOLT   3'h2
`define AIP_CFG_POT_CUR    3'h3
`define AIP_CFG_VOLT       3'h4
`define AIP_CFG_CUR        3'h5
`define AIP_IN_VOLT        2'h0
`define AIP_IN_CUR         2'h1
`define AIP_IN_POT         2'h2
`define AIP_IN_FIXED       2'h3

// Reset values and the maximum that offset and limit writes clamp to.
`define AIP_RST_FSRC       2'h1
`define AIP_RST_CFG        3'h2
`define AIP_RST_GAIN       8'h64
`define AIP_RST_OFFSET     7'h00
`define AIP_OFFSET_MAX     7'h64
`define AIP_RST_SCALE      16'h0100
`define AIP_RST_KP         8'h10
`define AIP_RST_LIMIT      7'h00

// Timing: update period in microseconds and clock rate in MHz.
`define AIP_UPDATE_US      1000
`define AIP_CLK_MHZ        40
`define AIP_UPDATE_CYCLES  (`AIP_UPDATE_US * `AIP_CLK_MHZ)

`endif

// [src/aip_monitor_scale.v]
// Gain and offset scaling of the analog monitor output code.
`timescale 1ns/1ps
`default_nettype none
module aip_monitor_scale #(
   parameter W = 10
) (
   // Value and settings.
   input  wire [W-1:0] value,
   input  wire [7:0]   gain,
   input  wire [6:0]   offset,
   // Scaled output code, full scale means +10V.
   output reg  [W-1:0] code
);
   localparam [W-1:0] FULL = {W{1'b1}};

   reg [W+23:0] prod;
   reg [W+16:0] ofs;
   reg [W+1:0]  sum;

   // Gain 100 gives unity; the divide by 100 is a multiply by 655/65536, a small under-read traded for no divider.
   // Offset is in tenths of a volt and simply adds after the gain, which is why the gain does not scale it.
   always @* begin
      prod = {14'h0000, value} * {16'h0000, gain} * 24'd655;
      ofs  = {{(W+10){1'b0}}, offset} * 17'd10476;
      sum  = {2'b00, prod[W+15:16]} + {2'b00, ofs[W+9:10]};
      if (prod[W+23:W+16] != 8'h00 || sum[W+1:W] != 2'b00) begin
         code = FULL;
      end else begin
         code = sum[W-1:0];
      end
   end
endmodule
`default_nettype wire

// [src/aip_top.v]
// Analog source selection, monitor output scaling and PID target frequency with APB registers.
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "aip_defs.vh"
module aip_top #(
   parameter W             = 10,
   parameter UPDATE_CYCLES = `AIP_UPDATE_CYCLES
) (
   // Clock, reset and enable.
   input  wire         clock,
   input  wire         rst,
   input  wire         clk_en,
   // APB slave.
   input  wire         psel,
   input  wire         penable,
   input  wire         pwrite,
   input  wire [7:0]   paddr,
   input  wire [31:0]  pwdata,
   output reg  [31:0]  prdata,
   output reg          pready,
   output reg          pslverr,
   // Analog samples, full scale is all ones.
   input  wire [W-1:0] voltage_input,
   input  wire [W-1:0] current_input,
   input  wire [W-1:0] pot_input,
   input  wire [W-1:0] output_current,
   // Logic input select line and whether a terminal carries it.
   input  wire         analog_type_select,
   input  wire         analog_type_assigned,
   // Results.
   output reg  [W-1:0] freq_command_q,
   output reg  [W-1:0] monitor_output_q,
   output reg          limit_active_q,
   output reg          source_conflict_q
);
   localparam [W-1:0] FULL = {W{1'b1}};
   localparam [31:0]  UPD_LAST = UPDATE_CYCLES - 1;

   // Picks the physical input for an analog command from the config code and select line.
   function [1:0] pick_input;
      input [2:0] cfg;
      input       sel_on;
      begin
         case (cfg)
            `AIP_CFG_POT_VOLT: pick_input = sel_on ? `AIP_IN_POT : `AIP_IN_VOLT;
            `AIP_CFG_POT_CUR:  pick_input = sel_on ? `AIP_IN_POT : `AIP_IN_CUR;
            `AIP_CFG_VOLT:     pick_input = `AIP_IN_VOLT;
            `AIP_CFG_CUR:      pick_input = `AIP_IN_CUR;
            default:           pick_input = sel_on ? `AIP_IN_POT : `AIP_IN_VOLT;
         endcase
      end
   endfunction

   // Percent 0..100 to a full-scale code.
   function [W-1:0] pct_code;
      input [6:0] pct;
      reg   [W+16:0] p;
      begin
         p = {{(W+10){1'b0}}, pct} * 17'd10476;
         pct_code = p[W+9:10];
      end
   endfunction

   // Configuration registers.
   reg [1:0]   freq_src_q;
   reg [2:0]   in_cfg_q;
   reg [W-1:0] fixed_freq_q;
   reg [7:0]   mon_gain_q;
   reg [6:0]   mon_offset_q;
   reg         mon_sel_q;
   reg         pid_en_q;
   reg         err_neg_q;
   reg         pv_cur_q;
   reg [6:0]   limit_q;
   reg [15:0]  scale_q;
   reg [7:0]   kp_q;
   // Loop state.
   reg [31:0]  upd_cnt_q;
   reg [W-1:0] pid_out_q;

   wire        acc   = psel & penable & pready;
   wire        wr    = acc & pwrite;
   wire        mapped = (paddr == `AIP_REG_SRC_CFG) || (paddr == `AIP_REG_FIXED_FREQ) ||
                        (paddr == `AIP_REG_MON_CFG) || (paddr == `AIP_REG_PID_CFG) ||
                        (paddr == `AIP_REG_PID_GAIN) || (paddr == `AIP_REG_STATUS);

   wire        sel_on = analog_type_assigned & analog_type_select;
   wire [1:0]  an_in = pick_input(in_cfg_q, sel_on);

   reg  [1:0]  ref_in;
   always @* begin
      case (freq_src_q)
         `AIP_FSRC_ANALOG: ref_in = an_in;
         `AIP_FSRC_FIXED:  ref_in = `AIP_IN_FIXED;
         default:          ref_in = `AIP_IN_POT;
      endcase
   end

   // Value of the selected reference.
   reg [W-1:0] ref_val;
   always @* begin
      case (ref_in)
         `AIP_IN_VOLT: ref_val = voltage_input;
         `AIP_IN_CUR:  ref_val = current_input;
         `AIP_IN_POT:  ref_val = pot_input;
         default:      ref_val = fixed_freq_q;
      endcase
   end

   // voltage and current exclusive
   // Setpoint and process variable on opposite analog inputs would need both at once, so the loop holds.
   wire conflict = pid_en_q &&
                   (((ref_in == `AIP_IN_VOLT) && pv_cur_q) || ((ref_in == `AIP_IN_CUR) && !pv_cur_q));

   wire [W-1:0] pv_raw = pv_cur_q ? current_input : voltage_input;

   // pv scale factor
   // Scale is unsigned 8.8 fixed point; the product saturates at full scale.
   wire [W+15:0] pv_prod = {16'h0000, pv_raw} * {{W{1'b0}}, scale_q};
   wire [W-1:0]  pv_f = (pv_prod[W+15:W+8] != 8'h00) ? FULL : pv_prod[W+7:8];

   wire signed [W+1:0] err_pos = $signed({2'b00, ref_val}) - $signed({2'b00, pv_f});
   wire signed [W+1:0] err     = err_neg_q ? -err_pos : err_pos;

   // step toward zero error
   // Proportional step per update; kp 64 means one code of output per code of error.
   wire signed [W+10:0] step = $signed({{9{err[W+1]}}, err}) * $signed({3'b000, kp_q});
   wire signed [W+4:0]  raw  = $signed({5'b00000, pid_out_q}) + $signed(step[W+10:6]);
   wire [W-1:0]         lin  = raw[W+4] ? {W{1'b0}} : ((raw[W+3:W] != 4'h0) ? FULL : raw[W-1:0]);

   wire [W-1:0] lim_code = pct_code(limit_q);
   wire         above    = (ref_val > lin) && ((ref_val - lin) > lim_code);
   wire         below    = (lin > ref_val) && ((lin - ref_val) > lim_code);
   wire [W:0]   hi_sum   = {1'b0, ref_val} + {1'b0, lim_code};
   wire [W-1:0] lim_out  = above ? (ref_val - lim_code) :
                           below ? (hi_sum[W] ? FULL : hi_sum[W-1:0]) : lin;

   wire [W-1:0] mon_val = mon_sel_q ? output_current : freq_command_q;
   wire [W-1:0] mon_code;
   aip_monitor_scale #(
      .W      (W)
   ) u_mon (
      .value  (mon_val),
      .gain   (mon_gain_q),
      .offset (mon_offset_q),
      .code   (mon_code)
   );

   // APB handshake: one wait cycle, then pready for one cycle of the access phase.
   always @(posedge clock) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else if (clk_en) begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped;
         if (psel & penable & ~pready & ~pwrite) begin
            case (paddr)
               `AIP_REG_SRC_CFG:    prdata <= {21'h000000, in_cfg_q, 6'h00, freq_src_q};
               `AIP_REG_FIXED_FREQ: prdata <= {{(32-W){1'b0}}, fixed_freq_q};
               `AIP_REG_MON_CFG:    prdata <= {15'h0000, mon_sel_q, 1'b0, mon_offset_q, mon_gain_q};
               `AIP_REG_PID_CFG:    prdata <= {scale_q, 1'b0, limit_q, 5'h00, pv_cur_q, err_neg_q, pid_en_q};
               `AIP_REG_PID_GAIN:   prdata <= {24'h000000, kp_q};
               `AIP_REG_STATUS:     prdata <= {14'h0000, source_conflict_q, limit_active_q, 2'b00,
                                               ref_in, {(12-W){1'b0}}, freq_command_q};
               default:             prdata <= 32'h00000000;
            endcase
         end
      end
   end

   // Register writes take effect at the completing edge of the access phase.
   always @(posedge clock) begin
      if (rst) begin
         freq_src_q   <= `AIP_RST_FSRC;
         in_cfg_q     <= `AIP_RST_CFG;
         fixed_freq_q <= {W{1'b0}};
         mon_gain_q   <= `AIP_RST_GAIN;
         mon_offset_q <= `AIP_RST_OFFSET;
         mon_sel_q    <= 1'b0;
         pid_en_q     <= 1'b0;
         err_neg_q    <= 1'b0;
         pv_cur_q     <= 1'b0;
         limit_q      <= `AIP_RST_LIMIT;
         scale_q      <= `AIP_RST_SCALE;
         kp_q         <= `AIP_RST_KP;
      end else if (clk_en && wr) begin
         case (paddr)
            `AIP_REG_SRC_CFG: begin
               freq_src_q <= pwdata[1:0];
               in_cfg_q   <= pwdata[10:8];
            end
            `AIP_REG_FIXED_FREQ: fixed_freq_q <= pwdata[W-1:0];
            `AIP_REG_MON_CFG: begin
               mon_gain_q   <= pwdata[7:0];
               mon_offset_q <= (pwdata[14:8] > `AIP_OFFSET_MAX) ? `AIP_OFFSET_MAX : pwdata[14:8];
               mon_sel_q    <= pwdata[16];
            end
            `AIP_REG_PID_CFG: begin
               pid_en_q  <= pwdata[0];
               err_neg_q <= pwdata[1];
               pv_cur_q  <= pwdata[2];
               limit_q   <= (pwdata[14:8] > `AIP_OFFSET_MAX) ? `AIP_OFFSET_MAX : pwdata[14:8];
               scale_q   <= pwdata[31:16];
            end
            `AIP_REG_PID_GAIN: kp_q <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // fixed update period
   // The loop advances only on the period tick, counted in clock-enabled cycles, so its rate does not depend on the bus but follows the clock enable duty.
   always @(posedge clock) begin
      if (rst) begin
         upd_cnt_q         <= 32'h00000000;
         pid_out_q         <= {W{1'b0}};
         limit_active_q    <= 1'b0;
         source_conflict_q <= 1'b0;
      end else if (clk_en) begin
         if (upd_cnt_q >= UPD_LAST) begin
            upd_cnt_q         <= 32'h00000000;
            source_conflict_q <= conflict;
            if (!pid_en_q) begin
               // Loop follows the reference while disabled so enabling starts without a jump.
               pid_out_q      <= ref_val;
               limit_active_q <= 1'b0;
            end else if (!conflict) begin
               pid_out_q      <= lim_out;
               limit_active_q <= above | below;
            end
         end else begin
            upd_cnt_q <= upd_cnt_q + 32'h00000001;
         end
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         freq_command_q   <= {W{1'b0}};
         monitor_output_q <= {W{1'b0}};
      end else if (clk_en) begin
         freq_command_q   <= pid_en_q ? pid_out_q : ref_val;
         monitor_output_q <= mon_code;
      end
   end
endmodule
`default_nettype wire

// [testbench/aip_sensor_model.sv]
// Model of the external sensors and transmitters feeding the analog samples.
`timescale 1ns/1ps
`default_nettype none
module aip_sensor_model #(
   parameter W = 10
) (
   // Clock.
   input  wire logic         clock,
   // Levels requested by the bench.
   input  wire logic [W-1:0] v_lvl,
   input  wire logic [W-1:0] c_lvl,
   input  wire logic [W-1:0] p_lvl,
   input  wire logic [W-1:0] i_lvl,
   // Converted samples.
   output var  logic [W-1:0] v_smp,
   output var  logic [W-1:0] c_smp,
   output var  logic [W-1:0] p_smp,
   output var  logic [W-1:0] i_smp
);
   // converter sampling
   // Samples lag the level by one edge, as a real converter would.
   always @(posedge clock) begin
      v_smp <= v_lvl;
      c_smp <= c_lvl;
      p_smp <= p_lvl;
      i_smp <= i_lvl;
   end
endmodule
`default_nettype wire

// [testbench/aip_top_monitor.sv]
// Concurrent checks on the ports of the analog source, monitor and PID block.
`timescale 1ns/1ps
`default_nettype none
module aip_top_monitor #(
   parameter W = 10
) (
   // Clock and reset.
   input wire logic         clock,
   input wire logic         rst,
   // Register bus.
   input wire logic         psel,
   input wire logic         penable,
   input wire logic         pwrite,
   input wire logic [7:0]   paddr,
   input wire logic [31:0]  pwdata,
   input wire logic         pready,
   input wire logic         pslverr,
   // Samples, select line and results.
   input wire logic [W-1:0] voltage_input,
   input wire logic [W-1:0] current_input,
   input wire logic [W-1:0] pot_input,
   input wire logic         analog_type_select,
   input wire logic         analog_type_assigned,
   input wire logic [W-1:0] freq_command_q,
   input wire logic         limit_active_q,
   input wire logic         source_conflict_q
);
   logic [1:0] fsrc_q;
   logic [2:0] cfg_q;
   logic       pid_q;
   logic [1:0] age_q;
   logic       wen;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   assign wen = psel && penable && pready && pwrite;
   // Shadow of the source settings; age keeps checks off until a new setting has settled.
   always @(posedge clock) begin
      if (rst) begin
         fsrc_q <= 2'h1;
         cfg_q <= 3'h2;
         pid_q <= 1'b0;
         age_q <= 2'h0;
      end else if (wen) begin
         age_q <= 2'h0;
         if (paddr == 8'h00) fsrc_q <= pwdata[1:0];
         if (paddr == 8'h00) cfg_q <= pwdata[10:8];
         if (paddr == 8'h0C) pid_q <= pwdata[0];
      end else if (age_q != 2'h3) begin
         age_q <= age_q + 2'h1;
      end
   end
   property p_ready_wait; psel && penable && !pready |=> pready; endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("pready late");
   property p_ready_pulse; pready |=> !pready; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
   property p_err_map; psel && penable && !pready |=> pslverr == (paddr > 8'h14 || paddr[1:0] != 2'h0); endproperty
   a_err_map: assert property (p_err_map) else $error("pslverr wrong");
   property p_idle; !psel |=> !pready; endproperty
   a_idle: assert property (p_idle) else $error("pready while idle");
   property p_flags; $changed({limit_active_q, source_conflict_q}) |=> $stable({limit_active_q, source_conflict_q})[*7]; endproperty
   a_flags: assert property (p_flags) else $error("flags off update period");
   property p_volt; age_q == 2'h3 && fsrc_q == 2'h1 && !pid_q && cfg_q == 3'h4 |-> freq_command_q == $past(voltage_input); endproperty
   a_volt: assert property (p_volt) else $error("voltage path wrong");
   property p_cur; age_q == 2'h3 && fsrc_q == 2'h1 && !pid_q && cfg_q == 3'h5 |-> freq_command_q == $past(current_input); endproperty
   a_cur: assert property (p_cur) else $error("current path wrong");
   property p_sel; age_q == 2'h3 && fsrc_q == 2'h1 && !pid_q && cfg_q == 3'h2 |-> freq_command_q ==
      ($past(analog_type_select && analog_type_assigned) ? $past(pot_input) : $past(voltage_input)); endproperty
   a_sel: assert property (p_sel) else $error("select path wrong");
   c_unmapped: cover property (pready && pslverr);
   c_limit: cover property ($rose(limit_active_q));
   c_conflict: cover property ($rose(source_conflict_q));
endmodule
bind aip_top aip_top_monitor #(.W(W)) i_mon (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .voltage_input(voltage_input), .current_input(current_input), .pot_input(pot_input),
   .analog_type_select(analog_type_select), .analog_type_assigned(analog_type_assigned),
   .freq_command_q(freq_command_q), .limit_active_q(limit_active_q), .source_conflict_q(source_conflict_q));
`default_nettype wire

// [testbench/tb_aip_top.sv]
// Self-checking bench for the analog source, monitor and PID block.
`timescale 1ns/1ps
`default_nettype none
module tb_aip_top;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        sel_line = 1'b0;
   logic        sel_asg = 1'b1;
   logic [9:0]  v_lvl = 10'h000;
   logic [9:0]  c_lvl = 10'h000;
   logic [9:0]  p_lvl = 10'h000;
   logic [9:0]  i_lvl = 10'h000;
   wire  [9:0]  v_smp, c_smp, p_smp, i_smp, freq, mon;
   wire  [31:0] prdata;
   wire         pready, pslverr, lim, conf;
   logic [31:0] q;
   logic        e;
   int          n_fail = 0;
   int          check_count = 0;
   logic [31:0] rv [5] = '{32'h0000_0201, 32'h0, 32'h0000_0064, 32'h0100_0000, 32'h0000_0010};
   logic [31:0] mv [4] = '{32'h0000_0064, 32'h0000_00C8, 32'h0000_0A64, 32'h0001_0064};
   // Free-running 40 MHz clock.
   always #12.5 clock = ~clock;
   aip_sensor_model #(.W(10)) i_sens (.clock(clock), .v_lvl(v_lvl), .c_lvl(c_lvl), .p_lvl(p_lvl),
      .i_lvl(i_lvl), .v_smp(v_smp), .c_smp(c_smp), .p_smp(p_smp), .i_smp(i_smp));
   aip_top #(.W(10), .UPDATE_CYCLES(8)) i_dut (.clock(clock), .rst(rst), .clk_en(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .voltage_input(v_smp), .current_input(c_smp),
      .pot_input(p_smp), .output_current(i_smp), .analog_type_select(sel_line),
      .analog_type_assigned(sel_asg), .freq_command_q(freq), .monitor_output_q(mon),
      .limit_active_q(lim), .source_conflict_q(conf));
   // One bit wider than the bus so the error flag can ride along with read data.
   task chk(input logic [32:0] got, input logic [32:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One bus transfer; the request is held until pready is seen high at an edge.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      // Only the watchdog ends a wait that never sees pready.
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task settle(input int n);
      repeat (n) @(posedge clock);
   endtask
   // The loop output moves only on update edges, so wait for it under a bound.
   task wait_freq(input logic [9:0] old);
      int n;
      n = 0;
      while (freq === old && n < 40) begin
         @(posedge clock);
         n++;
      end
   endtask
   task done(input string s);
      $display("test %s done", s);
   endtask
   task give_verdict;
      $display("checks=%0d mismatches=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   function automatic logic [9:0] src_exp(int cf, logic on);
      case (cf)
         4: return 10'h064;
         5: return 10'h0C8;
         2: return on ? 10'h12C : 10'h064;
         default: return on ? 10'h12C : 10'h0C8;
      endcase
   endfunction
   function automatic logic [9:0] mon_exp(int x, int g, int o);
      int r;
      r = (x * g * 655) / 65536 + (o * 10476) / 1024;
      return (r > 1023) ? 10'h3FF : r[9:0];
   endfunction
   // Watchdog sized well above the whole sequence.
   initial begin
      #(25 * 6000);
      n_fail++;
      give_verdict();
   end
   // Main sequence.
   initial begin
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      for (int k = 0; k < 5; k++) begin
         apb(1'b0, 8'(k * 4), 32'h0);
         chk(q, rv[k]);
      end
      apb(1'b0, 8'h18, 32'h0);
      chk({e, q}, 33'h1_0000_0000);
      wr(8'h08, 32'h0000_7F64);
      apb(1'b0, 8'h08, 32'h0);
      chk(q, 32'h0000_6464);
      done("registers");
      v_lvl <= 10'h064;
      c_lvl <= 10'h0C8;
      p_lvl <= 10'h12C;
      i_lvl <= 10'h190;
      for (int k = 0; k < 9; k++) begin
         sel_line <= k[0] || k == 8;
         sel_asg <= (k < 8);
         wr(8'h00, {21'h0, 3'(2 + k[2:1]), 8'h01});
         settle(4);
         chk(freq, src_exp(2 + k[2:1], k[0] && k < 8));
      end
      wr(8'h04, 32'h0000_0155);
      wr(8'h00, 32'h0000_0402);
      settle(4);
      chk(freq, 10'h155);
      wr(8'h00, 32'h0000_0400);
      settle(4);
      chk(freq, 10'h12C);
      done("sources");
      wr(8'h00, 32'h0000_0401);
      v_lvl <= 10'h200;
      for (int k = 0; k < 4; k++) begin
         wr(8'h08, {mv[k][31:8], 8'h64});
         wr(8'h08, mv[k]);
         settle(5);
         chk(mon, mon_exp(mv[k][16] ? 400 : 512, mv[k][7:0], mv[k][14:8]));
      end
      done("monitor");
      v_lvl <= 10'h0C8;
      p_lvl <= 10'h258;
      wr(8'h00, 32'h0000_0200);
      settle(20);
      chk(freq, 10'h258);
      wr(8'h0C, 32'h0100_0A01);
      wait_freq(10'h258);
      chk({lim, freq}, 11'h2BC);
      wr(8'h0C, 32'h0100_0000);
      settle(20);
      wr(8'h0C, 32'h0100_0501);
      wait_freq(10'h258);
      chk({lim, freq}, 11'h68B);
      wr(8'h0C, 32'h0100_0000);
      settle(20);
      wr(8'h0C, 32'h0100_0A03);
      wait_freq(10'h258);
      chk(freq, 10'h1F4);
      wr(8'h0C, 32'h0100_0000);
      wr(8'h00, 32'h0000_0401);
      settle(20);
      wr(8'h0C, 32'h0100_0A05);
      settle(20);
      chk({conf, freq}, 11'h4C8);
      apb(1'b0, 8'h14, 32'h0);
      chk(q, 32'h0002_00C8);
      done("pid");
      give_verdict();
   end
endmodule
`default_nettype wire
